/* hdl/dsa_pkg.sv */
// constants, field layouts and carriers for the dual setpoint alarm logic
// assumes a 250 MHz system clock and the plain register port of dsa_alarm_logic
package dsa_pkg;
  localparam int VAL_W = 18;
  localparam int TIME_W = 12;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 5;
  localparam int SEGS = 100;
  localparam int CHANS = 2;

  // timing
  localparam longint TICK_PERIOD_NS = 64'd1000000000;
  localparam longint CLK_PERIOD_NS = 64'd4;
  localparam int TICK_CYCLES_DEF = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [TIME_W-1:0] TIME_MAX = 12'hE10;

  // setpoint range in display units
  localparam logic signed [VAL_W-1:0] SP_MIN = -18'sd19999;
  localparam logic signed [VAL_W-1:0] SP_MIN_DZ = -18'sd19990;
  localparam logic signed [VAL_W-1:0] SP_MAX = 18'sd19999;
  localparam logic signed [VAL_W-1:0] SP_MAX_DZ = 18'sd99990;

  // register indices; channel block n starts at n * CH_STRIDE
  localparam logic [ADDR_W-1:0] CH_STRIDE = 5'h05;
  localparam logic [ADDR_W-1:0] REG_CH_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CH_SETPOINT = 5'h01;
  localparam logic [ADDR_W-1:0] REG_CH_HYST = 5'h02;
  localparam logic [ADDR_W-1:0] REG_CH_DELAY = 5'h03;
  localparam logic [ADDR_W-1:0] REG_CH_SILENCE = 5'h04;
  localparam logic [ADDR_W-1:0] REG_GCTRL = 5'h0A;
  localparam logic [ADDR_W-1:0] REG_ACCESS_CODE = 5'h0B;
  localparam logic [ADDR_W-1:0] REG_LIMIT_LO = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_LIMIT_HI = 5'h0D;
  localparam logic [ADDR_W-1:0] REG_BAR_BASE = 5'h0E;
  localparam logic [ADDR_W-1:0] REG_BAR_STEP = 5'h0F;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;

  // channel control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_HIGH = 1;
  localparam int CTRL_CLOSED = 2;
  localparam int CTRL_FLASH = 3;
  // global control bits
  localparam int G_DUMMY_ZERO = 0;
  localparam int G_ALT_ID = 1;
  localparam int G_ACCESS_EN = 2;
  // status bits per channel, channel n at n * STS_W
  localparam int STS_W = 4;

  typedef struct packed {
    logic en;
    logic high_low_sense;
    logic closed_in_alarm;
    logic flash;
    logic signed [VAL_W-1:0] setpoint;
    logic [VAL_W-1:0] hysteresis_value;
    logic [TIME_W-1:0] activation_delay;
    logic [TIME_W-1:0] silence_time;
  } dsa_chan_cfg_s;

  typedef struct packed {
    logic cond;
    logic pending;
    logic fired;
    logic silenced;
    logic alarm;
  } dsa_chan_sts_s;
endpackage

/* hdl/dsa_channel.sv */
// one alarm channel: condition with hysteresis, activation delay, silence timer
// assumes tick is a one-cycle pulse once per second and accept a one-cycle press
module dsa_channel (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input dsa_pkg::dsa_chan_cfg_s cfg, // channel settings
  input wire logic signed [dsa_pkg::VAL_W-1:0] value, // displayed value
  input wire logic tick, // one-second pulse
  input wire logic accept, // program button press
  output dsa_pkg::dsa_chan_sts_s sts // channel state
);
  import dsa_pkg::*;

  typedef struct packed {
    logic cond;
    logic fired;
    logic silenced;
    logic [TIME_W-1:0] dly_cnt;
    logic [TIME_W-1:0] sil_cnt;
  } dsa_ch_state_s;

  dsa_ch_state_s s;
  dsa_ch_state_s next_s;
  logic signed [VAL_W:0] v_x;
  logic signed [VAL_W:0] sp_x;
  logic signed [VAL_W:0] hys_x;
  logic hit;
  logic clr;

  assign v_x = {value[VAL_W-1], value};
  assign sp_x = {cfg.setpoint[VAL_W-1], cfg.setpoint};
  assign hys_x = {1'b0, cfg.hysteresis_value};

  always_comb begin
    next_s = s;
    hit = cfg.high_low_sense ? (v_x >= sp_x) : (v_x <= sp_x);
    clr = cfg.high_low_sense ? (v_x < sp_x - hys_x) : (v_x > sp_x + hys_x);
    if (!cfg.en) begin
      next_s.cond = 1'b0;
    end else if (hit) begin
      next_s.cond = 1'b1;
    end else if (clr) begin
      next_s.cond = 1'b0;
    end
    if (!next_s.cond) begin
      next_s.fired = 1'b0;
      next_s.silenced = 1'b0;
      next_s.dly_cnt = cfg.activation_delay;
    end else begin
      if (!s.cond) begin
        // fresh condition restarts the delay; zero fires at once
        next_s.dly_cnt = cfg.activation_delay;
        next_s.fired = (cfg.activation_delay == '0);
      end else if (!s.fired && tick) begin
        if (s.dly_cnt <= 12'h001) begin
          next_s.fired = 1'b1;
        end else begin
          next_s.dly_cnt = s.dly_cnt - 12'h001;
        end
      end
      if (s.fired && accept && cfg.silence_time != '0) begin
        // a second press while silenced restarts the silence time
        next_s.silenced = 1'b1;
        next_s.sil_cnt = cfg.silence_time;
      end else if (s.silenced && tick) begin
        if (s.sil_cnt <= 12'h001) begin
          next_s.silenced = 1'b0;
        end else begin
          next_s.sil_cnt = s.sil_cnt - 12'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sts.cond = s.cond;
  assign sts.pending = s.cond & ~s.fired;
  assign sts.fired = s.fired;
  assign sts.silenced = s.silenced;
  assign sts.alarm = s.fired & ~s.silenced;
endmodule

/* hdl/dsa_alarm_logic.sv */
// dual setpoint alarm logic: registers, tick, switch outputs, annunciators,
// setpoint bargraph and the direct setpoint path.
// assumes disp_value and buttons synchronous to clk; button inputs are one-cycle presses.
// How it works
// - two channels, each high or low sense, each output normally open or closed
// - enable bit stops a channel but keeps all of its stored settings
// - condition when value reaches setpoint; high alarm means value at or above setpoint
// - setpoint writes outside -19999..19999 (-19990..99990 with dummy zero) or limits refused
// - active high alarm clears only below setpoint minus hysteresis
// - output fires after programmed delay in whole seconds up to 3600; zero none
// - silence time is 0 to 3600 seconds in one-second steps
// - program button accepts alarms only when silence time is nonzero
// - accept of active alarm returns output to non-alarm for silence time
// - accepted, silenced alarm still shows active on its annunciator
// - with flash, annunciator blinks during delay, bar blinks after it
// - with flash, bar blinks on alarm; after accept annunciator blinks instead
// - per-channel flash setting decides whether setpoint bar blinks
// - with any alarm enabled, right bargraph marks the setpoint positions
// - reversed setpoints or high-then-low senses show two single segments
// - one enabled alarm draws column from setpoint to top (high) or bottom (low)
// - polarity bit picks open or closed switch in alarm condition
// - without loop power both switches are open
// - annunciators show both alarms; display may alternate with alarm id
// - direct setpoint path, enabled separately, guarded by own access code
//
// Chosen here: the placing of the registers and strobed register access.
module dsa_alarm_logic #(
  parameter int TICK_CYCLES = dsa_pkg::TICK_CYCLES_DEF // clocks per second
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [dsa_pkg::ADDR_W-1:0] reg_addr, // register index
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic signed [dsa_pkg::VAL_W-1:0] disp_value, // displayed value
  input wire logic loop_ok, // loop power present
  input wire logic accept_press, // program button press pulse
  input wire logic da_req, // direct setpoint change request pulse
  input wire logic da_sel, // 0 first_setpoint, 1 second_setpoint
  input wire logic [dsa_pkg::CODE_W-1:0] da_code, // operator access code
  input wire logic signed [dsa_pkg::VAL_W-1:0] da_value, // new setpoint
  output logic da_done, // direct change stored, pulse
  output logic da_refused, // direct change refused, pulse
  output logic [dsa_pkg::CHANS-1:0] switch_closed, // alarm switch closed
  output logic [dsa_pkg::CHANS-1:0] annunciator, // alarm annunciator lit
  output logic [dsa_pkg::SEGS-1:0] bargraph_right, // right bargraph segments
  output logic show_alarm_id, // numeric display shows alarm id
  output logic alarm_id_sel // which alarm id is shown
);
  import dsa_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    dsa_chan_cfg_s [CHANS-1:0] cfg;
    logic dummy_zero;
    logic alt_id;
    logic access_en;
    logic [CODE_W-1:0] access_code;
    logic signed [VAL_W-1:0] limit_lo;
    logic signed [VAL_W-1:0] limit_hi;
    logic signed [VAL_W-1:0] bar_base;
    logic [VAL_W-1:0] bar_step;
    logic [31:0] rdata;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic blink;
    logic id_phase;
    logic id_show;
    logic id_sel;
    logic da_done;
    logic da_refused;
    logic [CHANS-1:0] sw;
    logic [CHANS-1:0] ann;
    logic [SEGS-1:0] bar;
  } dsa_state_s;

  dsa_state_s s;
  dsa_state_s next_s;
  dsa_chan_sts_s [CHANS-1:0] sts;
  logic [CHANS-1:0][SEGS:0] above;
  logic [CHANS-1:0][SEGS-1:0] mark_v;
  logic [CHANS-1:0][SEGS-1:0] col_v;
  logic [CHANS-1:0][SEGS-1:0] show_v;
  logic [CHANS-1:0] bar_blank;
  logic accept_ok;

  // setpoint legality against absolute range and the 3.8/20.2 mA limits
  function automatic logic sp_legal(input logic signed [VAL_W-1:0] v, input logic dz,
                                    input logic signed [VAL_W-1:0] lo, input logic signed [VAL_W-1:0] hi);
    logic signed [VAL_W-1:0] mn;
    logic signed [VAL_W-1:0] mx;
    mn = dz ? SP_MIN_DZ : SP_MIN;
    mx = dz ? SP_MAX_DZ : SP_MAX;
    sp_legal = (v >= mn) && (v <= mx) && (v >= lo) && (v <= hi);
  endfunction

  // times above the longest allowed are held at it
  function automatic logic [TIME_W-1:0] time_clip(input logic [31:0] w);
    time_clip = (w > {20'h00000, TIME_MAX}) ? TIME_MAX : w[TIME_W-1:0];
  endfunction

  // channel index and offset within a channel block, or none
  function automatic logic [ADDR_W:0] ch_decode(input logic [ADDR_W-1:0] a);
    if (a < CH_STRIDE) begin
      ch_decode = {1'b1, 1'b0, a[ADDR_W-2:0]};
    end else if (a < 5'(2 * CH_STRIDE)) begin
      ch_decode = {1'b1, 1'b1, 4'(a - CH_STRIDE)};
    end else begin
      ch_decode = '0;
    end
  endfunction

  // each channel's own state machine
  generate
    for (genvar c = 0; c < CHANS; c++) begin : g_ch
      dsa_channel u_ch (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(s.cfg[c]),
        .value(disp_value),
        .tick(s.tick),
        .accept(accept_ok),
        .sts(sts[c])
      );
      // segment i spans [base + i*step, base + (i+1)*step)
      for (genvar i = 0; i <= SEGS; i++) begin : g_thr
        logic signed [VAL_W+8:0] thr;
        assign thr = (VAL_W+9)'(s.bar_base) + $signed({1'b0, 8'(i)}) * $signed({1'b0, s.bar_step});
        assign above[c][i] = thr <= (VAL_W+9)'(s.cfg[c].setpoint);
      end
      for (genvar i = 0; i < SEGS; i++) begin : g_seg
        assign mark_v[c][i] = above[c][i] & ~above[c][i+1];
        assign col_v[c][i] = s.cfg[c].high_low_sense ? ~above[c][i+1] : above[c][i];
      end
      // bar blinks while the output is in alarm, stops once silenced
      assign bar_blank[c] = s.cfg[c].flash & sts[c].alarm & s.blink;
    end
  endgenerate

  // button is an accept only where a silence time is set; channel checks its own
  assign accept_ok = accept_press;

  always_comb begin
    logic [ADDR_W:0] dec;
    logic ch;
    logic both_en;
    logic any_en;
    logic band;
    logic signed [VAL_W-1:0] wv;
    next_s = s;
    dec = ch_decode(reg_addr);
    ch = dec[ADDR_W-1];
    wv = reg_wdata[VAL_W-1:0];
    both_en = s.cfg[0].en & s.cfg[1].en;
    any_en = s.cfg[0].en | s.cfg[1].en;
    band = ~s.cfg[0].high_low_sense & s.cfg[1].high_low_sense & (s.cfg[0].setpoint < s.cfg[1].setpoint);

    // one-second tick and blink phase
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
    end
    if (s.tick) begin
      next_s.blink = ~s.blink;
      next_s.id_phase = ~s.id_phase;
    end
    // alternate measured value with the id of an active alarm, one second each
    next_s.id_show = s.alt_id & (sts[0].cond | sts[1].cond) & s.id_phase;
    next_s.id_sel = ~sts[0].cond;

    // register writes
    if (reg_wr) begin
      if (dec[ADDR_W]) begin
        unique case (dec[ADDR_W-2:0])
          4'(REG_CH_CTRL): begin
            next_s.cfg[ch].en = reg_wdata[CTRL_EN];
            next_s.cfg[ch].high_low_sense = reg_wdata[CTRL_HIGH];
            next_s.cfg[ch].closed_in_alarm = reg_wdata[CTRL_CLOSED];
            next_s.cfg[ch].flash = reg_wdata[CTRL_FLASH];
          end
          4'(REG_CH_SETPOINT): begin
            if (sp_legal(wv, s.dummy_zero, s.limit_lo, s.limit_hi)) begin
              next_s.cfg[ch].setpoint = wv;
            end
          end
          4'(REG_CH_HYST): next_s.cfg[ch].hysteresis_value = reg_wdata[VAL_W-1:0];
          4'(REG_CH_DELAY): next_s.cfg[ch].activation_delay = time_clip(reg_wdata);
          4'(REG_CH_SILENCE): next_s.cfg[ch].silence_time = time_clip(reg_wdata);
          default: ;
        endcase
      end else begin
        unique case (reg_addr)
          REG_GCTRL: begin
            next_s.dummy_zero = reg_wdata[G_DUMMY_ZERO];
            next_s.alt_id = reg_wdata[G_ALT_ID];
            next_s.access_en = reg_wdata[G_ACCESS_EN];
          end
          REG_ACCESS_CODE: next_s.access_code = reg_wdata[CODE_W-1:0];
          REG_LIMIT_LO: next_s.limit_lo = wv;
          REG_LIMIT_HI: next_s.limit_hi = wv;
          REG_BAR_BASE: next_s.bar_base = wv;
          REG_BAR_STEP: next_s.bar_step = reg_wdata[VAL_W-1:0];
          default: ;
        endcase
      end
    end

    // register reads, answered the next cycle
    next_s.rdata = '0;
    if (reg_rd) begin
      if (dec[ADDR_W]) begin
        unique case (dec[ADDR_W-2:0])
          4'(REG_CH_CTRL): next_s.rdata = {28'h0000000, s.cfg[ch].flash, s.cfg[ch].closed_in_alarm,
                                            s.cfg[ch].high_low_sense, s.cfg[ch].en};
          4'(REG_CH_SETPOINT): next_s.rdata = 32'(s.cfg[ch].setpoint);
          4'(REG_CH_HYST): next_s.rdata = {14'h0000, s.cfg[ch].hysteresis_value};
          4'(REG_CH_DELAY): next_s.rdata = {20'h00000, s.cfg[ch].activation_delay};
          4'(REG_CH_SILENCE): next_s.rdata = {20'h00000, s.cfg[ch].silence_time};
          default: next_s.rdata = '0;
        endcase
      end else begin
        unique case (reg_addr)
          REG_GCTRL: next_s.rdata = {29'h00000000, s.access_en, s.alt_id, s.dummy_zero};
          REG_ACCESS_CODE: next_s.rdata = {16'h0000, s.access_code};
          REG_LIMIT_LO: next_s.rdata = 32'(s.limit_lo);
          REG_LIMIT_HI: next_s.rdata = 32'(s.limit_hi);
          REG_BAR_BASE: next_s.rdata = 32'(s.bar_base);
          REG_BAR_STEP: next_s.rdata = {14'h0000, s.bar_step};
          REG_STATUS: next_s.rdata = {24'h000000,
                                      sts[1].silenced, sts[1].fired, sts[1].pending, sts[1].cond,
                                      sts[0].silenced, sts[0].fired, sts[0].pending, sts[0].cond};
          default: next_s.rdata = '0;
        endcase
      end
    end

    // direct setpoint path; a bus write to setpoints in the same cycle wins
    next_s.da_done = 1'b0;
    next_s.da_refused = 1'b0;
    if (da_req) begin
      if (s.access_en && (s.access_code == '0 || s.access_code == da_code)
          && sp_legal(da_value, s.dummy_zero, s.limit_lo, s.limit_hi)
          && !(reg_wr && dec[ADDR_W] && dec[ADDR_W-2:0] == 4'(REG_CH_SETPOINT))) begin
        next_s.cfg[da_sel].setpoint = da_value;
        next_s.da_done = 1'b1;
      end else begin
        next_s.da_refused = 1'b1;
      end
    end

    // switch outputs and annunciators
    for (int c = 0; c < CHANS; c++) begin
      // polarity chosen by setting, but a dead loop opens every switch
      next_s.sw[c] = loop_ok & (sts[c].alarm ? s.cfg[c].closed_in_alarm : ~s.cfg[c].closed_in_alarm);
      // lit while condition holds, silenced or not
      next_s.ann[c] = sts[c].cond;
      if (s.cfg[c].flash && (sts[c].pending || sts[c].silenced) && s.blink) begin
        next_s.ann[c] = 1'b0;
      end
    end

    // setpoint bargraph
    for (int c = 0; c < CHANS; c++) begin
      show_v[c] = '0;
    end
    if (both_en) begin
      if (band) begin
        show_v[0] = col_v[0];
        show_v[1] = col_v[1];
      end else begin
        show_v[0] = mark_v[0];
        show_v[1] = mark_v[1];
      end
    end else if (any_en) begin
      show_v[0] = s.cfg[0].en ? col_v[0] : '0;
      show_v[1] = s.cfg[1].en ? col_v[1] : '0;
    end
    next_s.bar = (bar_blank[0] ? '0 : show_v[0]) | (bar_blank[1] ? '0 : show_v[1]);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign show_alarm_id = s.id_show;
  assign alarm_id_sel = s.id_sel;
  assign reg_rdata = s.rdata;
  assign da_done = s.da_done;
  assign da_refused = s.da_refused;
  assign switch_closed = s.sw;
  assign annunciator = s.ann;
  assign bargraph_right = s.bar;
endmodule

/* testbench/dsa_alarm_logic_properties.sv */
// port-level checks for dsa_alarm_logic, bound into every instance
// assumes reg_rdata and da answers are registered one cycle after the strobe
module dsa_alarm_logic_properties
  import dsa_pkg::*;
#(
  parameter int TICK_CYCLES = 8 // clocks per tick
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // register index
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic loop_ok, // loop power
  input wire logic da_req, // direct request
  input wire logic da_done, // direct stored
  input wire logic da_refused, // direct refused
  input wire logic [CHANS-1:0] switch_closed // switch outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_read_of(logic [ADDR_W-1:0] a);
    $past(reg_rd) && ($past(reg_addr) == a);
  endsequence
  sequence s_power_lost;
    !loop_ok ##1 !loop_ok;
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > REG_STATUS |-> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  status_width_a: assert property (s_read_of(REG_STATUS) |-> reg_rdata[31:8] == 24'h0)
    else $error("status has bits above channel fields");
  delay_cap_a: assert property (s_read_of(REG_CH_DELAY) |-> reg_rdata <= 32'h00000E10)
    else $error("activation delay above 3600");
  silence_cap_a: assert property (s_read_of(REG_CH_SILENCE) |-> reg_rdata <= 32'h00000E10)
    else $error("silence time above 3600");
  power_off_open_a: assert property (s_power_lost |-> switch_closed == 2'h0)
    else $error("switch closed without loop power");
  close_needs_power_a: assert property ($rose(switch_closed[0]) || $rose(switch_closed[1]) |-> $past(loop_ok))
    else $error("switch closed after power loss");
  direct_answer_a: assert property (da_req |=> da_done || da_refused)
    else $error("direct request got no answer");
  direct_excl_a: assert property (!(da_done && da_refused))
    else $error("direct request both stored and refused");
  direct_spurious_a: assert property (!$past(da_req) |-> !da_done && !da_refused)
    else $error("direct answer without request");
endmodule

bind dsa_alarm_logic dsa_alarm_logic_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .loop_ok(loop_ok), .da_req(da_req), .da_done(da_done), .da_refused(da_refused),
  .switch_closed(switch_closed)
);

/* testbench/dsa_sounder_model.sv */
// sounder wired across one alarm switch output
// assumes the sounder is energised whenever the switch is closed
module dsa_sounder_model (
  input wire logic clk, // system clock
  input wire logic closed, // switch closed
  output logic sounding, // sounder energised
  output int closures // count of switch closures
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  assign sounding = closed;
  initial closures = 0;
  always @(posedge clk) begin
    if (closed === 1'b1 && last === 1'b0) begin
      closures++;
    end
    last <= closed;
  end
endmodule

/* testbench/dsa_alarm_logic_tb.sv */
// self-checking bench for dsa_alarm_logic with a short tick
// assumes dsa_pkg register map and the sounder model
module dsa_alarm_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dsa_pkg::*;
  localparam int TK = 8;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, loop_ok = 1'b1;
  logic accept_press = 1'b0, da_req = 1'b0, da_sel = 1'b0, da_done, da_refused, show_alarm_id, alarm_id_sel;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rv;
  logic signed [VAL_W-1:0] disp_value = '0, da_value = '0;
  logic [CODE_W-1:0] da_code = '0;
  logic [CHANS-1:0] switch_closed, annunciator;
  logic [SEGS-1:0] bargraph_right;
  logic sounding;
  int failures = 0, n_checks = 0, seed = 32'hef9c6db7, v, cond, k, n_ann, n_bar, n_id;
  dsa_alarm_logic #(.TICK_CYCLES(TK)) uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .disp_value(disp_value), .loop_ok(loop_ok), .accept_press(accept_press), .da_req(da_req),
    .da_sel(da_sel), .da_code(da_code), .da_value(da_value), .da_done(da_done),
    .da_refused(da_refused), .switch_closed(switch_closed), .annunciator(annunciator),
    .bargraph_right(bargraph_right), .show_alarm_id(show_alarm_id), .alarm_id_sel(alarm_id_sel));
  dsa_sounder_model u_snd (.clk(clk), .closed(switch_closed[0]), .sounding(sounding), .closures());
  initial forever #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // counts lit cycles over two ticks; a blinking output is lit for half of them
  task automatic watch(output int na, output int nb, output int ni);
    na = 0;
    nb = 0;
    ni = 0;
    repeat (2 * TK) begin
      cyc(1);
      na += annunciator[0];
      nb += bargraph_right[99];
      ni += show_alarm_id;
    end
  endtask
  task automatic drive(input int val);
    @(posedge clk);
    disp_value <= VAL_W'(val);
  endtask
  task automatic press;
    @(posedge clk);
    accept_press <= 1'b1;
    @(posedge clk);
    accept_press <= 1'b0;
  endtask
  task automatic direct(input logic [15:0] code, input int val, input logic exp_ok);
    @(posedge clk);
    da_code <= code;
    da_value <= VAL_W'(val);
    da_req <= 1'b1;
    @(posedge clk);
    da_req <= 1'b0;
    #1 chk("da_done", {31'h0, exp_ok}, {31'h0, da_done});
    chk("da_refused", {31'h0, !exp_ok}, {31'h0, da_refused});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wr(REG_LIMIT_LO, 32'hFFFFB1E1);
    wr(REG_LIMIT_HI, 32'h00004E1F);
    wr(REG_CH_SETPOINT, 32'd100);
    wr(REG_CH_SETPOINT, 32'd30000);
    rd(REG_CH_SETPOINT, rv);
    chk("setpoint", 32'd100, rv);
    wr(REG_CH_DELAY, 32'd5000);
    rd(REG_CH_DELAY, rv);
    chk("delay", 32'h00000E10, rv);
    wr(REG_CH_SILENCE, 32'd9999);
    rd(REG_CH_SILENCE, rv);
    chk("silence", 32'h00000E10, rv);
    wr(REG_GCTRL, 32'h2);
    wr(REG_BAR_BASE, 32'd0);
    wr(REG_BAR_STEP, 32'd10);
    rd(5'h1F, rv);
    chk("unmapped", 32'h0, rv);
    wr(REG_CH_DELAY, 32'd0);
    wr(REG_CH_HYST, 32'd10);
    wr(REG_CH_CTRL, 32'h7);
    $display("registers done");
    cond = 0;
    for (k = 0; k < 40; k++) begin
      v = 80 + ({$random(seed)} % 40);
      drive(v);
      cond = (v >= 100) ? 1 : ((v < 90) ? 0 : cond);
      cyc(4);
      chk("switch0", cond, {31'h0, switch_closed[0]});
      chk("sounder", cond, {31'h0, sounding});
      chk("annunciator0", cond, {31'h0, annunciator[0]});
    end
    $display("hysteresis done");
    drive(120);
    wr(REG_CH_SILENCE, 32'd2);
    cyc(3);
    press();
    cyc(4);
    chk("silenced switch", 32'h0, {31'h0, switch_closed[0]});
    chk("silenced annunciator", 32'h1, {31'h0, annunciator[0]});
    k = 0;
    while (switch_closed[0] !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    chk("silence end", 32'h1, (k >= 60) ? 32'h0 : 32'h1);
    wr(REG_CH_SILENCE, 32'd0);
    press();
    cyc(4);
    chk("accept ignored", 32'h1, {31'h0, switch_closed[0]});
    $display("silence done");
    drive(0);
    wr(REG_CH_DELAY, 32'd4);
    wr(REG_CH_CTRL, 32'hF);
    cyc(3);
    drive(120);
    cyc(4);
    chk("pending switch", 32'h0, {31'h0, switch_closed[0]});
    rd(REG_STATUS, rv);
    chk("pending status", 32'h3, rv);
    watch(n_ann, n_bar, n_id);
    chk("pending annunciator blink", TK, n_ann);
    chk("pending bar steady", 2 * TK, n_bar);
    chk("id alternates", TK, n_id);
    cyc(4 * TK);
    chk("delayed switch", 32'h1, {31'h0, switch_closed[0]});
    watch(n_ann, n_bar, n_id);
    chk("alarm annunciator steady", 2 * TK, n_ann);
    chk("alarm bar blink", TK, n_bar);
    chk("id of alarm one", 32'h0, {31'h0, alarm_id_sel});
    @(posedge clk);
    loop_ok <= 1'b0;
    cyc(3);
    chk("no power", 32'h0, {30'h0, switch_closed});
    @(posedge clk);
    loop_ok <= 1'b1;
    wr(REG_CH_CTRL, 32'h3);
    cyc(3);
    chk("open in alarm", 32'h0, {31'h0, switch_closed[0]});
    $display("delay and polarity done");
    cyc(3);
    chk("high column", 32'h2, {30'h0, bargraph_right[99], bargraph_right[0]});
    wr(REG_CH_CTRL, 32'h5);
    cyc(3);
    chk("low column", 32'h1, {30'h0, bargraph_right[99], bargraph_right[0]});
    wr(CH_STRIDE + REG_CH_SETPOINT, 32'd500);
    wr(CH_STRIDE + REG_CH_CTRL, 32'h3);
    cyc(3);
    chk("band", 32'h5, {29'h0, bargraph_right[99], bargraph_right[20], bargraph_right[0]});
    wr(CH_STRIDE + REG_CH_SETPOINT, 32'd50);
    cyc(3);
    chk("marks", 32'h6, {28'h0, bargraph_right[99], bargraph_right[10], bargraph_right[5], bargraph_right[0]});
    wr(REG_CH_CTRL, 32'h4);
    rd(REG_CH_SETPOINT, rv);
    chk("kept setpoint", 32'd100, rv);
    $display("bargraph done");
    wr(REG_GCTRL, 32'h4);
    wr(REG_ACCESS_CODE, 32'h1234);
    direct(16'h1111, 200, 1'b0);
    direct(16'h1234, 30000, 1'b0);
    direct(16'h1234, 200, 1'b1);
    rd(REG_CH_SETPOINT, rv);
    chk("direct setpoint", 32'd200, rv);
    $display("direct access done");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED run length expected end seen timeout");
    final_report();
  end
endmodule
